// ---- core/cda_counter.sv ----
`timescale 1ns/100ps
`default_nettype none
// saturating up/down counter with limit indicators
module cda_counter #(
	parameter int W = 7
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         clr,
	input  wire logic         load,
	input  wire logic [W-1:0] loadVal,
	input  wire logic         inc,
	input  wire logic         dec,
	input  wire logic [W-1:0] maxVal,
	output logic [W-1:0]      count,
	output logic              atMax,
	output logic              atMin
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         atMax;
		logic         atMin;
	} cda_cnt_state_t;

	cda_cnt_state_t state_q;
	cda_cnt_state_t state_d;

	// clear beats load beats stepping; never wraps
	always_comb begin
		state_d = state_q;
		if (clr) begin
			state_d.cnt = '0;
		end else if (load) begin
			state_d.cnt = loadVal;
		end else if (inc && !dec && state_q.cnt < maxVal) begin
			state_d.cnt = state_q.cnt + 1'b1;
		end else if (dec && !inc && state_q.cnt != '0) begin
			state_d.cnt = state_q.cnt - 1'b1;
		end
		state_d.atMax = state_d.cnt >= maxVal;
		state_d.atMin = state_d.cnt == '0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= '{cnt: '0, atMax: 1'b0, atMin: 1'b1};
		end else begin
			state_q <= state_d;
		end
	end

	assign count = state_q.cnt;
	assign atMax = state_q.atMax;
	assign atMin = state_q.atMin;
endmodule
`default_nettype wire

// ---- core/cda_pkg.sv ----
package cda_pkg;
	// character limits
	localparam logic [6:0] X_LAST     = 7'h4f; // 79
	localparam logic [4:0] Y_LAST_24  = 5'h17; // 23
	localparam logic [4:0] Y_LAST_12  = 5'h0b; // 11
	localparam logic [6:0] CHAR_CTRL  = 7'h20; // below: control chars
	localparam logic [6:0] CHAR_LOWER = 7'h60; // from here: lower case
	localparam logic [1:0] POST_DISP  = 2'h2;  // steps after display
	// apb map
	localparam logic [7:0] ADDR_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_CUR   = 8'h04;
	localparam logic [7:0] ADDR_DISP  = 8'h08;
	localparam int         CTRL_LINES12 = 0;
	localparam int         F_X_LO   = 0;
	localparam int         F_Y_LO   = 8;
	localparam int         F_EOL    = 16;
	localparam int         F_LAST   = 17;
	localparam int         F_TOP    = 18;
	localparam int         F_LEFT   = 19;
	localparam logic       LINES12_RST = 1'b0;

	// pins from the minibus and timing source
	typedef struct packed {
		logic       vsync;
		logic       display;
		logic       dma;
		logic       step;
		logic       store;
		logic       strobe;
		logic       xfer;
		logic       readPh;
		logic       up;
		logic       down;
		logic       left;
		logic       right;
		logic       xClear;
		logic       yClear;
		logic       xSel;
		logic       ySel;
		logic [6:0] data;
		logic [6:0] ramRd;
	} cda_pins_t;

	typedef struct packed {
		cda_pins_t   meta;
		cda_pins_t   sync;
		cda_pins_t   prev;
		logic        lines12;
		logic [1:0]  postDisp;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic [6:0]  busOut;
		logic        busOe;
		logic        ramWe;
		logic [6:0]  ramWrData;
		logic [6:0]  addrX;
		logic [4:0]  addrY;
	} cda_top_state_t;
endpackage

// ---- core/cda_top.sv ----
// Functional notes
// - loaded X cursor takes the seven data bits, Y cursor the low five
// - X select plus store and strobe loads X
// - X load refused for control characters
// - Y select plus store and strobe loads Y
// - Y load refused for control or lower case
// - X select at read drives X cursor out
// - Y select at read drives Y cursor out
// - Y display cleared locally from vsync and step
// - x_clear clears the X display register
// - counters saturate, never wrap by themselves
// - X display line end blocks further right steps
// - X left edge blocks decrements, increment releases
// - Y display stops at top and last line
// - Y cursor like Y display, both with a top flag
// - no select: read RAM, store writes RAM
// - select: store presets, read returns coordinate
// - cursor counts frozen during DMA
// - DMA commands act on display at step
// - DMA steps, up+down and left+right preset limits
// - DMA transfer of cursor count with select
// - RAM address: display regs or cursor regs
`timescale 1ns/100ps
`default_nettype none
module cda_top (
	input  wire logic        clk,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// timing source and sequencer pins
	input  wire cda_pkg::cda_pins_t pinsIn,
	// minibus data lines, two-way
	output logic [6:0]       busOut,
	output logic             busOe,
	// ram side
	output logic [6:0]       ramAddrX,
	output logic [4:0]       ramAddrY,
	output logic             ramWe,
	output logic [6:0]       ramWrData,
	// register indicators
	output logic             xDispAtLineEnd,
	output logic             xCurAtLineEnd,
	output logic             yDispAtLastLine,
	output logic             yCurAtLastLine,
	output logic             yCurAtTop,
	output logic             xAtLeftEdge,
	output logic             xDispAtLeftEdge,
	output logic             yDispAtTop
);
	cda_pkg::cda_top_state_t state_q;
	cda_pkg::cda_top_state_t state_d;

	logic [6:0] xCur;
	logic [4:0] yCur;
	logic [6:0] xDisp;
	logic [4:0] yDisp;
	logic [4:0] yLast;
	logic       stepPulse;
	logic       storePulse;
	logic       ioTime;
	logic       xCharOk;
	logic       yCharOk;
	logic       xCurLoad;
	logic       yCurLoad;
	logic       curStep;
	logic       xDispClr;
	logic       yDispClr;
	logic       xDispLoad;
	logic       yDispLoad;
	logic [6:0] xDispVal;
	logic [4:0] yDispVal;
	logic       dispStep;
	cda_pkg::cda_pins_t s;

	assign s = state_q.sync;

	// strobes and qualifiers from synchronised pins
	always_comb begin
		stepPulse  = s.step && !state_q.prev.step;
		storePulse = (s.store && s.strobe)
			&& !(state_q.prev.store && state_q.prev.strobe);
		ioTime     = !s.display && !s.dma;
		yLast      = state_q.lines12 ? cda_pkg::Y_LAST_12 : cda_pkg::Y_LAST_24;
	end

	// cursor loading from the minibus
	always_comb begin
		xCharOk  = s.data >= cda_pkg::CHAR_CTRL;
		yCharOk  = s.data >= cda_pkg::CHAR_CTRL
			&& s.data < cda_pkg::CHAR_LOWER;
		xCurLoad = storePulse && s.xSel && !s.dma && xCharOk;
		yCurLoad = storePulse && s.ySel && !s.xSel && !s.dma && yCharOk;
		curStep  = stepPulse && ioTime;
	end

	// display register commands
	always_comb begin
		dispStep  = stepPulse && (s.dma || s.display);
		xDispClr  = stepPulse && s.xClear;
		yDispClr  = stepPulse && (s.yClear
			|| (s.vsync && !s.display));
		xDispLoad = dispStep && s.dma && s.left && s.right;
		xDispVal  = s.xSel ? xCur : cda_pkg::X_LAST;
		yDispLoad = dispStep && s.dma && s.up && s.down
			&& !s.xSel;
		yDispVal  = s.ySel ? yCur : yLast;
	end

	// x cursor register
	cda_counter #(.W(7)) xCurCnt (
		.clk     (clk),
		.rst_n   (rst_n),
		.clr     (curStep && s.xClear),
		.load    (xCurLoad),
		.loadVal (s.data),
		.inc     (curStep && s.right),
		.dec     (curStep && s.left),
		.maxVal  (cda_pkg::X_LAST),
		.count   (xCur),
		.atMax   (xCurAtLineEnd),
		.atMin   (xAtLeftEdge)
	);

	// y cursor register
	cda_counter #(.W(5)) yCurCnt (
		.clk     (clk),
		.rst_n   (rst_n),
		.clr     (curStep && s.yClear),
		.load    (yCurLoad),
		.loadVal (s.data[4:0]),
		.inc     (curStep && s.down),
		.dec     (curStep && s.up),
		.maxVal  (yLast),
		.count   (yCur),
		.atMax   (yCurAtLastLine),
		.atMin   (yCurAtTop)
	);

	// x display register
	cda_counter #(.W(7)) xDispCnt (
		.clk     (clk),
		.rst_n   (rst_n),
		.clr     (xDispClr),
		.load    (xDispLoad),
		.loadVal (xDispVal),
		.inc     (dispStep && s.right),
		.dec     (dispStep && s.left),
		.maxVal  (cda_pkg::X_LAST),
		.count   (xDisp),
		.atMax   (xDispAtLineEnd),
		.atMin   (xDispAtLeftEdge)
	);

	// y display register
	cda_counter #(.W(5)) yDispCnt (
		.clk     (clk),
		.rst_n   (rst_n),
		.clr     (yDispClr),
		.load    (yDispLoad),
		.loadVal (yDispVal),
		.inc     (dispStep && s.down),
		.dec     (dispStep && s.up),
		.maxVal  (yLast),
		.count   (yDisp),
		.atMax   (yDispAtLastLine),
		.atMin   (yDispAtTop)
	);

	// next state: sync, apb, minibus, ram
	always_comb begin
		state_d      = state_q;
		state_d.meta = pinsIn;
		state_d.sync = state_q.meta;
		state_d.prev = state_q.sync;

		// display-address hold for two steps after display ends
		if (s.display) begin
			state_d.postDisp = cda_pkg::POST_DISP;
		end else if (stepPulse && state_q.postDisp != 2'h0) begin
			state_d.postDisp = state_q.postDisp - 2'h1;
		end

		// ram address source
		if (s.display || s.dma || state_q.postDisp != 2'h0) begin
			state_d.addrX = xDisp;
			state_d.addrY = yDisp;
		end else begin
			state_d.addrX = xCur;
			state_d.addrY = yCur;
		end

		// minibus read answer
		state_d.busOe = s.readPh;
		if (s.xSel && !s.dma) begin
			state_d.busOut = xCur;
		end else if (s.ySel && !s.dma) begin
			state_d.busOut = {2'h0, yCur};
		end else begin
			state_d.busOut = s.ramRd;
		end

		// ram write on transfer strobe at strobe with store
		state_d.ramWe     = s.xfer && s.strobe && (s.store || s.dma)
			&& !s.xSel && !s.ySel;
		state_d.ramWrData = s.data;

		// apb: answer one cycle after setup
		state_d.pready  = psel && !penable;
		state_d.pslverr = 1'b0;
		state_d.prdata  = 32'h0;
		if (psel && !penable) begin
			case (paddr)
				cda_pkg::ADDR_CTRL: begin
					state_d.prdata[cda_pkg::CTRL_LINES12] = state_q.lines12;
				end
				cda_pkg::ADDR_CUR: begin
					state_d.prdata[cda_pkg::F_X_LO +: 7] = xCur;
					state_d.prdata[cda_pkg::F_Y_LO +: 5] = yCur;
					state_d.prdata[cda_pkg::F_EOL]       = xCurAtLineEnd;
					state_d.prdata[cda_pkg::F_LAST]      = yCurAtLastLine;
					state_d.prdata[cda_pkg::F_TOP]       = yCurAtTop;
					state_d.prdata[cda_pkg::F_LEFT]      = xAtLeftEdge;
				end
				cda_pkg::ADDR_DISP: begin
					state_d.prdata[cda_pkg::F_X_LO +: 7] = xDisp;
					state_d.prdata[cda_pkg::F_Y_LO +: 5] = yDisp;
					state_d.prdata[cda_pkg::F_EOL]       = xDispAtLineEnd;
					state_d.prdata[cda_pkg::F_LAST]      = yDispAtLastLine;
					state_d.prdata[cda_pkg::F_TOP]       = yDispAtTop;
					state_d.prdata[cda_pkg::F_LEFT]      = xDispAtLeftEdge;
				end
				default: begin
					state_d.pslverr = 1'b1;
				end
			endcase
		end
		if (psel && penable && state_q.pready && pwrite
			&& paddr == cda_pkg::ADDR_CTRL) begin
			state_d.lines12 = pwdata[cda_pkg::CTRL_LINES12];
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q         <= '0;
			state_q.lines12 <= cda_pkg::LINES12_RST;
		end else begin
			state_q <= state_d;
		end
	end

	assign pready    = state_q.pready;
	assign prdata    = state_q.prdata;
	assign pslverr   = state_q.pslverr;
	assign busOut    = state_q.busOut;
	assign busOe     = state_q.busOe;
	assign ramAddrX  = state_q.addrX;
	assign ramAddrY  = state_q.addrY;
	assign ramWe     = state_q.ramWe;
	assign ramWrData = state_q.ramWrData;
endmodule
`default_nettype wire

// ---- test/cda_edit_seq.sv ----
`timescale 1ns/100ps
`default_nettype none
// edit sequencer card: drives minibus and timing pins
module cda_edit_seq (
	input  wire logic             clk,
	input  wire logic [6:0]       busOut,
	output var cda_pkg::cda_pins_t pins
);
	initial pins = '0;
	// hold one command four edges, then release with inverted data
	task automatic issue(input logic [15:0] f, input logic [6:0] d, output logic [6:0] seen);
		@(posedge clk);
		pins <= {f, d, 7'h5a};
		repeat (4) @(posedge clk);
		seen = busOut;
		pins <= {16'h0, ~d, 7'h25};
		repeat (4) @(posedge clk);
	endtask
	// position cursor: x char then y char
	task automatic posCursor(input logic [6:0] x, input logic [6:0] y);
		logic [6:0] s;
		issue(16'h0c02, x, s);
		issue(16'h0c01, y, s);
	endtask
	// read cursor: x byte then y byte
	task automatic readCursor(output logic [6:0] x, output logic [6:0] y);
		issue(16'h0102, 7'h00, x);
		issue(16'h0101, 7'h00, y);
	endtask
endmodule
`default_nettype wire

// ---- test/cda_top_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
// pin-to-output relations of the cursor block
module cda_top_monitor (
	input wire logic               clk,
	input wire logic               rst_n,
	input wire cda_pkg::cda_pins_t pinsIn,
	input wire logic               busOe,
	input wire logic               ramWe,
	input wire logic [6:0]         ramWrData,
	input wire logic               xDispAtLineEnd,
	input wire logic               xCurAtLineEnd,
	input wire logic               yDispAtLastLine,
	input wire logic               yCurAtLastLine,
	input wire logic               yCurAtTop,
	input wire logic               xAtLeftEdge,
	input wire logic               xDispAtLeftEdge,
	input wire logic               yDispAtTop
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic ramWeExp;
	// write condition as the pins show it
	assign ramWeExp = pinsIn.xfer && pinsIn.strobe && (pinsIn.store || pinsIn.dma)
		&& !pinsIn.xSel && !pinsIn.ySel;
	// a register never sits at both limits
	a_xcur_limits: assert property (xCurAtLineEnd |-> !xAtLeftEdge)
		else $error("cursor x at both limits");
	a_xdisp_limits: assert property (xDispAtLineEnd |-> !xDispAtLeftEdge)
		else $error("display x at both limits");
	a_ycur_limits: assert property (yCurAtLastLine |-> !yCurAtTop)
		else $error("cursor y at both limits");
	a_ydisp_limits: assert property (yDispAtLastLine |-> !yDispAtTop)
		else $error("display y at both limits");
	// minibus drive follows read phase after sync and register
	a_bus_drive: assert property (busOe == $past(pinsIn.readPh, 3))
		else $error("bus drive not tied to read phase");
	// ram write only on strobe with store or dma and no select
	a_ram_write: assert property (ramWe == $past(ramWeExp, 3))
		else $error("ram write enable wrong");
	a_ram_data: assert property (ramWe |-> ramWrData == $past(pinsIn.data, 3))
		else $error("ram write data wrong");
	// cursor left-edge, top and line-end flags frozen while dma is held
	a_dma_freeze: assert property (pinsIn.dma [*4] |-> $stable(xAtLeftEdge)
		&& $stable(yCurAtTop) && $stable(xCurAtLineEnd))
		else $error("cursor moved in dma");
	c_ram_write: cover property (ramWe);
	c_disp_end: cover property (xDispAtLineEnd && yDispAtLastLine);
	c_bus_read: cover property (busOe);
endmodule
bind cda_top cda_top_monitor mon (.clk, .rst_n, .pinsIn, .busOe, .ramWe, .ramWrData,
	.xDispAtLineEnd, .xCurAtLineEnd, .yDispAtLastLine, .yCurAtLastLine, .yCurAtTop,
	.xAtLeftEdge, .xDispAtLeftEdge, .yDispAtTop);
`default_nettype wire

// ---- test/cursor_display_address_registers_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module cursor_display_address_registers_bench;
	logic               clk, rst_n, psel, penable, pwrite, pready, pslverr, busOe, ramWe, er;
	logic [7:0]         paddr, flg;
	logic [31:0]        pwdata, prdata, rd;
	logic [6:0]         busOut, ramAddrX, ramWrData, sx, sy;
	logic [4:0]         ramAddrY;
	cda_pkg::cda_pins_t pins;
	int                 n_mismatch = 0;
	int                 comparisons = 0;
	int                 cycles = 0;
	cda_top dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .pinsIn(pins), .busOut, .busOe, .ramAddrX, .ramAddrY, .ramWe, .ramWrData,
		.xDispAtLineEnd(flg[0]), .xCurAtLineEnd(flg[1]), .yDispAtLastLine(flg[2]),
		.yCurAtLastLine(flg[3]), .yCurAtTop(flg[4]), .xAtLeftEdge(flg[5]),
		.xDispAtLeftEdge(flg[6]), .yDispAtTop(flg[7]));
	cda_edit_seq seq (.clk, .busOut, .pins);
	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic summarize();
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// cut a hang short
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer, waits for pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, rd, er);
		chk(rd, exp);
	endtask
	// reset values and an unmapped address
	task automatic tReset();
		rdc(cda_pkg::ADDR_CUR, 32'h000c0000);
		rdc(cda_pkg::ADDR_DISP, 32'h000c0000);
		apb(1'b0, 8'h0c, 32'h0, rd, er);
		chk({er, rd[30:0]}, 32'h80000000);
	endtask
	// cursor loads, refusals, read-back and ram access
	task automatic tCursor();
		seq.posCursor(7'h41, 7'h25);
		rdc(cda_pkg::ADDR_CUR, 32'h00000541);
		seq.posCursor(7'h1f, 7'h65);
		rdc(cda_pkg::ADDR_CUR, 32'h00000541);
		seq.posCursor(7'h4f, 7'h37);
		rdc(cda_pkg::ADDR_CUR, 32'h0003174f);
		chk({20'h0, ramAddrY, ramAddrX}, 32'h00000bcf);
		seq.readCursor(sx, sy);
		chk({18'h0, sx, sy}, {18'h0, 7'h4f, 7'h17});
		seq.issue(16'h0100, 7'h00, sx);
		chk({25'h0, sx}, 32'h5a);
		seq.issue(16'h0e00, 7'h2a, sx);
	endtask
	// dma presets, saturation, clear, hold and transfer
	task automatic tDma();
		seq.issue(16'h3030, 7'h00, sx);
		seq.issue(16'h3010, 7'h00, sx);
		seq.issue(16'h3020, 7'h00, sx);
		seq.issue(16'h30c0, 7'h00, sx);
		seq.issue(16'h3040, 7'h00, sx);
		seq.issue(16'h3080, 7'h00, sx);
		rdc(cda_pkg::ADDR_DISP, 32'h0000164e);
		rdc(cda_pkg::ADDR_CUR, 32'h0003174f);
		seq.issue(16'h3008, 7'h00, sx);
		seq.issue(16'h3020, 7'h00, sx);
		seq.issue(16'h3000, 7'h00, sx);
		rdc(cda_pkg::ADDR_DISP, 32'h00081600);
		seq.issue(16'h3032, 7'h00, sx);
		seq.issue(16'h30c1, 7'h00, sx);
		rdc(cda_pkg::ADDR_DISP, 32'h0003174f);
		chk({24'h0, flg}, 32'h0000000f);
	endtask
	// local y clear, wrap by x clear with down, twelve-line preset
	task automatic tLocal();
		seq.issue(16'h9000, 7'h00, sx);
		rdc(cda_pkg::ADDR_DISP, 32'h0005004f);
		seq.issue(16'h3048, 7'h00, sx);
		rdc(cda_pkg::ADDR_DISP, 32'h00080100);
		apb(1'b1, cda_pkg::ADDR_CTRL, 32'h1, rd, er);
		rdc(cda_pkg::ADDR_CTRL, 32'h00000001);
		seq.issue(16'h30c0, 7'h00, sx);
		rdc(cda_pkg::ADDR_DISP, 32'h000a0b00);
	endtask
	// ram address keeps display regs until two steps after display
	task automatic tAddr();
		seq.issue(16'h4000, 7'h00, sx);
		chk({20'h0, ramAddrY, ramAddrX}, 32'h00000580);
		seq.issue(16'h1000, 7'h00, sx);
		chk({20'h0, ramAddrY, ramAddrX}, 32'h00000580);
		seq.issue(16'h1000, 7'h00, sx);
		chk({20'h0, ramAddrY, ramAddrX}, 32'h00000bcf);
	endtask
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		tReset();
		tCursor();
		tDma();
		tLocal();
		tAddr();
		summarize();
	end
endmodule
`default_nettype wire
